// *** src/pwc_pkg.sv ***
// Constants and types for the sector write engine
package pwc_pkg;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_DATA = 8'h00; // Data words in
   localparam logic [7:0] OFS_ERR = 8'h04; // Error read, writes ignored
   localparam logic [7:0] OFS_SCNT = 8'h08; // Sector count
   localparam logic [7:0] OFS_SNUM = 8'h0c; // Sector number
   localparam logic [7:0] OFS_CYLL = 8'h10; // Cylinder low
   localparam logic [7:0] OFS_CYLH = 8'h14; // Cylinder high
   localparam logic [7:0] OFS_DH = 8'h18; // Device/head
   localparam logic [7:0] OFS_CMD = 8'h1c; // Status read, command write
   localparam logic [7:0] OFS_CTL = 8'h20; // Device control
   localparam logic [7:0] OFS_MULT = 8'h24; // Block size in sectors
   // ****************************************
   // Opcodes, fields and reset values
   // ****************************************
   localparam logic [7:0] OP_FUA = 8'hce; // Multiple write, forced
   localparam logic [6:0] OP_WR_HI = 7'h18; // 30h/31h without bit 0
   localparam int ST_BSY = 7; // Status bit positions
   localparam int ST_RDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_IDN = 4; // Error bit positions
   localparam int ER_ABT = 2;
   localparam int CTL_HOB = 7; // High order byte select
   localparam int DH_LBA = 6; // Addressing mode bit
   localparam logic [16:0] CNT48_ZERO = 17'h10000; // 65,536 sectors
   localparam logic [16:0] CNT28_ZERO = 17'h00100; // 256 sectors
   localparam logic [7:0] RST_MULT = 8'h01; // Block size after reset
   localparam logic [7:0] RST_DH = 8'ha0; // Device/head after reset
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_DRQ = 2'b01,
      S_DRAIN = 2'b10,
      S_FLUSH = 2'b11
   } pwc_state_t;
   typedef struct packed {
      logic [15:0] data; // Payload word
      logic [47:0] addr; // Sector address or CHS tuple
      logic lba; // Address is logical
   } pwc_media_t;
endpackage

// *** src/pwc_track.sv ***
// Sector address and remaining-count tracker
`timescale 1ns/10ps
module pwc_track (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // Control
   input wire logic load,
   input wire logic [47:0] lba_in,
   input wire logic [16:0] cnt_in,
   input wire logic step,
   // State
   output logic [47:0] addr_q,
   output logic [16:0] remain_q
);
   // Step address per finished sector
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 48'h0;
         remain_q <= 17'h0;
      end else if (ce && load) begin
         addr_q <= lba_in;
         remain_q <= cnt_in;
      end else if (ce && step && remain_q != 17'h0) begin
         addr_q <= addr_q + 48'h1;
         remain_q <= remain_q - 17'h1;
      end
   end
endmodule

// *** src/pwc_core.sv ***
// Task-file write command engine behind an AHB-Lite slave
// Operation
// [R1] Opcode CEh starts forced multiple 48-bit write
// [R2] Forced write flushes media before ending status
// [R3] One interrupt per configured block
// [R4] Payload arrives as 16-bit data words
// [R5] Every requested sector goes to media
// [R6] 48-bit count: current low, previous high
// [R7] 48-bit count zero means 65,536
// [R8] 48-bit address from current/previous bytes
// [R9] Failure address readback, high byte select
// [R10] Opcodes 30h/31h start basic write
// [R11] Uncorrectable error stops at failing sector
// [R12] Basic count zero means 256
// [R13] Sector number: sector or address 7:0
// [R14] Cylinder bytes: cylinder or address 23:8
// [R15] Head field: head or address 27:24
// [R16] Retry bit ignored
// [R17] Count reads back sectors not transferred
// [R18] Address registers show last sector; on success the code shows the sector after it
// [R19] Ending status: ready, error only on failure
// [R20] Host loads parameters first, data on request
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
module pwc_core #(
   parameter int WORDS_PER_SECTOR = 256
) (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Host interrupt line
   output logic intrq,
   // Media write path
   output logic media_valid,
   input wire logic media_ready,
   output pwc_pkg::pwc_media_t media_word,
   output logic media_flush,
   input wire logic media_flush_done,
   input wire logic media_err,
   input wire logic media_err_nf
);
   localparam int WCW = $clog2(WORDS_PER_SECTOR);
   localparam logic [WCW-1:0] WC_LAST = WCW'(WORDS_PER_SECTOR - 1);

   // ****************************************
   // Bus front end
   // ****************************************
   logic wr_q; // Write data phase pending
   logic [7:0] wa_q; // Its offset
   logic [31:0] hrdata_q; // Read data, loaded at address phase
   pwc_pkg::pwc_state_t st_q; // Command state
   logic mv_q; // Media word pending
   pwc_pkg::pwc_media_t mw_q; // Media word held

   wire acc = ce & hsel & htrans[1] & hready; // Address phase taken
   wire acc_rd = acc & ~hwrite;
   wire [7:0] ra = haddr[7:0];
   // Data write waits for the media
   wire stall = wr_q & (wa_q == pwc_pkg::OFS_DATA) & mv_q; // [R4]
   wire commit = wr_q & ce & ~stall;
   wire w_data = commit & (wa_q == pwc_pkg::OFS_DATA);
   wire w_cmd = commit & (wa_q == pwc_pkg::OFS_CMD);
   wire w_ctl = commit & (wa_q == pwc_pkg::OFS_CTL);
   wire w_mult = commit & (wa_q == pwc_pkg::OFS_MULT);
   wire w_dh = commit & (wa_q == pwc_pkg::OFS_DH);
   wire w_tf = commit & (wa_q >= pwc_pkg::OFS_SCNT) &
      (wa_q <= pwc_pkg::OFS_CYLH);
   wire [1:0] tf_idx = 2'(wa_q[4:2] - 3'h2);

   assign hreadyout = ce & ~stall;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // Capture address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h0;
      end else if (ce && (acc || !stall)) begin
         wr_q <= acc & hwrite;
         wa_q <= ra;
      end
   end

   // ****************************************
   // Task file
   // ****************************************
   logic [7:0] cur_q [4]; // Count, sector, cyl low, cyl high
   logic [7:0] prv_q [4]; // Previously written bytes
   logic [7:0] dh_q; // Device/head
   logic [7:0] ctl_q; // Device control
   logic [7:0] mult_q; // Block size from set-multiple

   // Each count/sector/cylinder write in idle shifts current into previous
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 4; i++) begin
            cur_q[i] <= 8'h0;
            prv_q[i] <= 8'h0;
         end
         dh_q <= pwc_pkg::RST_DH;
         ctl_q <= 8'h0;
         mult_q <= pwc_pkg::RST_MULT;
      end else if (ce && st_q == pwc_pkg::S_IDLE) begin
         if (w_tf) begin
            prv_q[tf_idx] <= cur_q[tf_idx];
            cur_q[tf_idx] <= hwdata[7:0];
         end
         if (w_dh)
            dh_q <= hwdata[7:0];
         if (w_ctl)
            ctl_q <= hwdata[7:0];
         if (w_mult)
            mult_q <= hwdata[7:0];
      end
   end

   // ****************************************
   // Command decode
   // ****************************************
   wire [7:0] op = hwdata[7:0];
   wire is_fua = op == pwc_pkg::OP_FUA; // [R1]
   wire is_basic = op[7:1] == pwc_pkg::OP_WR_HI; // [R10] [R16]
   wire start = w_cmd & (st_q == pwc_pkg::S_IDLE);
   wire lba_mode = dh_q[pwc_pkg::DH_LBA];
   // Previous bytes: upper half
   wire [47:0] lba48 = {prv_q[3], prv_q[2], prv_q[1],
      cur_q[3], cur_q[2], cur_q[1]}; // [R8]
   // Logical or CHS, one layout
   wire [47:0] lba28 = {20'h0, dh_q[3:0], cur_q[3], cur_q[2],
      cur_q[1]}; // [R13] [R14] [R15]
   wire [15:0] c48 = {prv_q[0], cur_q[0]}; // [R6]
   wire [16:0] cnt48 = (c48 == 16'h0) ? pwc_pkg::CNT48_ZERO :
      {1'b0, c48}; // [R7]
   wire [16:0] cnt28 = (cur_q[0] == 8'h0) ? pwc_pkg::CNT28_ZERO :
      {9'h0, cur_q[0]}; // [R12]

   // ****************************************
   // Sector tracking
   // ****************************************
   logic [47:0] addr;
   logic [16:0] remain;
   logic [WCW-1:0] wc_q; // Word within sector
   logic [7:0] blk_q; // Sectors left in block
   logic fua_q; // Forced multiple command running
   logic lba_q; // Addressing mode latched at start
   wire word_in = w_data & (st_q == pwc_pkg::S_DRQ);
   wire sec_done = word_in & (wc_q == WC_LAST);
   wire blk_end = sec_done & ((blk_q == 8'h1) | (remain == 17'h1));
   wire [7:0] blk_size = (fua_q && mult_q != 8'h0) ? mult_q : 8'h1;

   pwc_track u_track (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .load(start & (is_fua | is_basic)),
      .lba_in(is_fua ? lba48 : lba28),
      .cnt_in(is_fua ? cnt48 : cnt28),
      .step(sec_done), // [R5]
      .addr_q(addr),
      .remain_q(remain)
   );

   // ****************************************
   // Command state machine
   // ****************************************
   logic err_q; // Command failed
   logic [7:0] erb_q; // Error register
   logic done_q; // Result readback active
   logic intrq_q; // Pending host interrupt
   logic flush_q; // Media flush request
   wire fail = media_err | media_err_nf;
   wire run = st_q != pwc_pkg::S_IDLE;
   // Drain over, last media word taken
   wire drained = (st_q == pwc_pkg::S_DRAIN) & ~mv_q;
   wire finish = (drained & (remain == 17'h0) & ~fua_q) |
      ((st_q == pwc_pkg::S_FLUSH) & media_flush_done) |
      (run & fail) | (start & ~is_fua & ~is_basic);
   wire blk_irq = drained & (remain != 17'h0);
   wire st_rd = acc_rd & (ra == pwc_pkg::OFS_CMD);

   // Media error cuts the command short
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= pwc_pkg::S_IDLE;
      end else if (ce) begin
         case (st_q)
            pwc_pkg::S_IDLE:
               if (start && (is_fua || is_basic))
                  st_q <= pwc_pkg::S_DRQ;
            pwc_pkg::S_DRQ:
               if (fail)
                  st_q <= pwc_pkg::S_IDLE; // [R11]
               else if (blk_end)
                  st_q <= pwc_pkg::S_DRAIN;
            pwc_pkg::S_DRAIN:
               if (fail || (drained && remain == 17'h0 && !fua_q))
                  st_q <= pwc_pkg::S_IDLE;
               else if (drained && remain == 17'h0)
                  st_q <= pwc_pkg::S_FLUSH; // [R2]
               else if (drained)
                  st_q <= pwc_pkg::S_DRQ;
            pwc_pkg::S_FLUSH:
               if (fail || media_flush_done)
                  st_q <= pwc_pkg::S_IDLE; // [R2]
            default:
               st_q <= pwc_pkg::S_IDLE;
         endcase
      end
   end

   // Word and block counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wc_q <= '0;
         blk_q <= 8'h0;
         fua_q <= 1'b0;
         lba_q <= 1'b0;
      end else if (ce) begin
         if (start) begin
            fua_q <= is_fua;
            lba_q <= is_fua | lba_mode;
            wc_q <= '0;
            blk_q <= (is_fua && mult_q != 8'h0) ? mult_q : 8'h1; // [R3]
         end else if (blk_irq) begin
            blk_q <= blk_size;
         end else if (word_in) begin
            wc_q <= sec_done ? '0 : wc_q + WCW'(1);
            if (sec_done)
               blk_q <= blk_q - 8'h1;
         end
      end
   end

   // Ending status and error bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_q <= 1'b0;
         erb_q <= 8'h0;
         done_q <= 1'b0;
      end else if (ce) begin
         if (start) begin
            err_q <= ~is_fua & ~is_basic;
            erb_q <= (is_fua | is_basic) ? 8'h0 :
               8'h1 << pwc_pkg::ER_ABT;
            done_q <= 1'b0;
         end else if (run && fail) begin
            err_q <= 1'b1; // [R19]
            erb_q <= media_err_nf ? 8'h1 << pwc_pkg::ER_IDN :
               8'h1 << pwc_pkg::ER_ABT;
         end
         if (finish && !start)
            done_q <= 1'b1;
         else if (w_tf || w_dh)
            done_q <= 1'b0;
      end
   end

   // New event beats status read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         intrq_q <= 1'b0;
      else if (ce) begin
         if (blk_irq || finish)
            intrq_q <= 1'b1; // [R3]
         else if (st_rd)
            intrq_q <= 1'b0;
      end
   end
   assign intrq = intrq_q;

   // ****************************************
   // Media path
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mv_q <= 1'b0;
         mw_q <= '0;
         flush_q <= 1'b0;
      end else if (ce) begin
         if (run && fail)
            mv_q <= 1'b0; // [R11]
         else if (word_in) begin
            mv_q <= 1'b1; // [R4] [R5]
            mw_q.data <= hwdata[15:0];
            mw_q.addr <= addr;
            mw_q.lba <= lba_q;
         end else if (media_ready)
            mv_q <= 1'b0;
         flush_q <= (st_q == pwc_pkg::S_FLUSH) & ~media_flush_done &
            ~fail;
      end
   end
   assign media_valid = mv_q;
   assign media_word = mw_q;
   assign media_flush = flush_q;

   // ****************************************
   // Read back
   // ****************************************
   wire high_order_byte_select = ctl_q[pwc_pkg::CTL_HOB];
   wire busy = (st_q == pwc_pkg::S_DRAIN) | (st_q == pwc_pkg::S_FLUSH);
   wire [7:0] status = {busy, ~busy, 1'b0, ~busy,
      st_q == pwc_pkg::S_DRQ, 2'b00, err_q}; // [R19]
   // Failing or next sector; hob picks half
   wire [7:0] r_cnt = high_order_byte_select ? remain[15:8] : remain[7:0]; // [R17]
   wire [7:0] r_sn = high_order_byte_select ? addr[31:24] : addr[7:0]; // [R9] [R18]
   wire [7:0] r_cl = high_order_byte_select ? addr[39:32] : addr[15:8]; // [R9] [R18]
   wire [7:0] r_ch = high_order_byte_select ? addr[47:40] : addr[23:16]; // [R9] [R18]
   wire [7:0] r_dh = {dh_q[7:4], lba_q ? addr[27:24] : dh_q[3:0]};
   wire [7:0] rd_byte =
      (ra == pwc_pkg::OFS_ERR) ? erb_q :
      (ra == pwc_pkg::OFS_SCNT) ? (done_q ? r_cnt : cur_q[0]) :
      (ra == pwc_pkg::OFS_SNUM) ? (done_q ? r_sn : cur_q[1]) :
      (ra == pwc_pkg::OFS_CYLL) ? (done_q ? r_cl : cur_q[2]) :
      (ra == pwc_pkg::OFS_CYLH) ? (done_q ? r_ch : cur_q[3]) :
      (ra == pwc_pkg::OFS_DH) ? (done_q ? r_dh : dh_q) :
      (ra == pwc_pkg::OFS_CMD) ? status :
      (ra == pwc_pkg::OFS_CTL) ? ctl_q :
      (ra == pwc_pkg::OFS_MULT) ? mult_q : 8'h0;

   // Latched at address phase: zero wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata_q <= 32'h0;
      else if (acc_rd)
         hrdata_q <= {24'h0, rd_byte};
   end

   // ****************************************
   // Checks
   // ****************************************
   a_start_fua: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && start && is_fua |=> st_q == pwc_pkg::S_DRQ && fua_q) // [R1]
      else $error("forced write did not start");
   a_start_basic: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && start && is_basic |=> st_q == pwc_pkg::S_DRQ && !fua_q)
      else $error("basic write did not start"); // [R10] [R16]
   a_flush_end: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && $fell(busy) && $past(st_q) == pwc_pkg::S_FLUSH &&
      !err_q |-> $past(media_flush_done)) // [R2]
      else $error("forced write ended before flush");
   a_zero_cnt48: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && start && is_fua && c48 == 16'h0 |=> remain == 17'h10000)
      else $error("48-bit zero count wrong"); // [R7]
   a_zero_cnt28: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && start && is_basic && cur_q[0] == 8'h0 |=> remain == 17'h100)
      else $error("basic zero count wrong"); // [R12]
   a_addr_load: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && start && is_fua |=> addr == $past(lba48)) // [R8]
      else $error("48-bit address wrong");
   a_word_media: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && word_in && !fail |=> mv_q && mw_q.data == $past(hwdata[15:0]))
      else $error("data word not forwarded"); // [R4]
   a_err_stop: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && run && fail |=> st_q == pwc_pkg::S_IDLE && !mv_q &&
      err_q ##1 !mv_q) // [R11]
      else $error("write not stopped on error");
   a_block_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && blk_irq |=> intrq_q && st_q == pwc_pkg::S_DRQ &&
      blk_q == $past(blk_size)) // [R3]
      else $error("block interrupt missing");
   a_end_status: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && finish |=> status[pwc_pkg::ST_RDY] &&
      !status[pwc_pkg::ST_BSY] && intrq_q) // [R19]
      else $error("ending status wrong");
endmodule

// *** verif/pwc_media_model.sv ***
// Media partner: paced sink, flush, errors
`timescale 1ns/10ps
module pwc_media_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Scenario control
   input wire logic slow,
   input wire logic err_en,
   input wire logic err_nf,
   input wire logic [15:0] err_at,
   // Media write path
   input wire logic media_valid,
   output logic media_ready,
   input wire logic media_flush,
   output logic media_flush_done,
   output logic media_err,
   output logic media_err_nf,
   // Progress
   output logic [15:0] taken_q,
   output logic [7:0] flush_cnt_q
);
   logic [1:0] div_q; // Pacing divider for slow mode
   logic [3:0] fl_wait_q; // Flush latency counter
   logic fired_q; // One error per arming
   // Refuse the chosen word
   wire hit = err_en && !fired_q && taken_q == err_at && media_valid &&
      !media_ready;
   // ****************************************
   // Sink, error and flush
   // ****************************************
   // One-cycle ready, never a double take
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 2'd0;
         fl_wait_q <= 4'd0;
         fired_q <= 1'b0;
         media_ready <= 1'b0;
         media_flush_done <= 1'b0;
         media_err <= 1'b0;
         media_err_nf <= 1'b0;
         taken_q <= 16'd0;
         flush_cnt_q <= 8'd0;
      end else begin
         div_q <= div_q + 2'd1;
         media_ready <= media_valid && !media_ready && !hit &&
            (!slow || div_q == 2'd0);
         if (media_valid && media_ready) begin
            taken_q <= taken_q + 16'd1;
         end
         media_err <= hit && !err_nf;
         media_err_nf <= hit && err_nf;
         fired_q <= err_en && (fired_q || hit);
         // Flush answers after ten cycles
         media_flush_done <= media_flush && fl_wait_q == 4'd9;
         fl_wait_q <= (media_flush && fl_wait_q != 4'd9) ?
            fl_wait_q + 4'd1 : 4'd0;
         if (media_flush && fl_wait_q == 4'd9) begin
            flush_cnt_q <= flush_cnt_q + 8'd1;
         end
      end
   end
endmodule

// *** verif/pio_sector_write_commands_tb.sv ***
// Bench for the sector write engine
`timescale 1ns/10ps
module pio_sector_write_commands_tb;
   localparam int WPS = 4; // Short sectors
   // ****************************************
   // Scenario rows
   // ****************************************
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] mult;
      logic [7:0] dh;
      logic [31:0] prv; // {cylh, cyll, snum, count}
      logic [31:0] cur;
      logic [7:0] nsec; // Sectors sent whole
      logic [1:0] err; // 1 uncorrectable, 2 not found
      logic [47:0] start;
      logic [15:0] remain;
      logic slow;
   } pwc_tb_row_t;
   pwc_tb_row_t rows [6];
   // Bus and media signals
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, intrq, media_valid, media_ready, media_flush;
   logic [31:0] hrdata;
   logic media_flush_done, media_err, media_err_nf;
   pwc_pkg::pwc_media_t media_word;
   logic slow = 1'b0;
   logic err_en = 1'b0;
   logic err_nf = 1'b0;
   logic [15:0] err_at = 16'h0;
   logic [15:0] taken_q;
   logic [7:0] flush_cnt_q;
   logic [31:0] rd_q; // Last read data
   pwc_pkg::pwc_media_t got_q [$]; // Words seen by the media
   int fail_count = 0;
   int check_count = 0;
   wire hready = hreadyout; // One slave
   always #5 hclk = ~hclk;
   pwc_core #(.WORDS_PER_SECTOR(WPS)) pwc_core_i (
      .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .intrq(intrq),
      .media_valid(media_valid), .media_ready(media_ready),
      .media_word(media_word), .media_flush(media_flush),
      .media_flush_done(media_flush_done), .media_err(media_err),
      .media_err_nf(media_err_nf));
   pwc_media_model pwc_media_model_i (
      .hclk(hclk), .hresetn(hresetn), .slow(slow), .err_en(err_en),
      .err_nf(err_nf), .err_at(err_at), .media_valid(media_valid),
      .media_ready(media_ready), .media_flush(media_flush),
      .media_flush_done(media_flush_done), .media_err(media_err),
      .media_err_nf(media_err_nf), .taken_q(taken_q),
      .flush_cnt_q(flush_cnt_q));
   // Words taken by media
   always @(posedge hclk) begin
      if (media_valid === 1'b1 && media_ready === 1'b1) begin
         got_q.push_back(media_word);
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic close_out;
      $display("Checks %0d, bad %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic bail;
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      close_out();
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t value %h, want %h", $time, got, exp);
      end
   endtask
   task automatic chk_media(input pwc_pkg::pwc_media_t got,
      input pwc_pkg::pwc_media_t exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t media %h, want %h", $time, got, exp);
      end
   endtask
   // Ready seen just before its edge
   task automatic wait_rdy;
      int n = 0;
      do begin
         @(negedge hclk);
         rd_q = hrdata;
         n++;
      end while (hreadyout !== 1'b1 && n < 200);
      if (n >= 200) bail();
      @(posedge hclk);
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [15:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_rdy();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= {16'h0, d};
      wait_rdy();
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 16'h0);
      chk_reg(rd_q, exp);
   endtask
   task automatic wait_irq;
      int n = 0;
      while (intrq !== 1'b1 && n < 3000) begin
         @(negedge hclk);
         n++;
      end
      if (n >= 3000) bail();
   endtask
   task automatic poll_drq;
      int n = 0;
      do begin
         ahb(1'b0, pwc_pkg::OFS_CMD, 16'h0);
         n++;
      end while (rd_q[pwc_pkg::ST_DRQ] !== 1'b1 && n < 100);
      chk_reg(rd_q, 32'h58);
   endtask
   // ****************************************
   // One command
   // ****************************************
   task automatic run_row(input int r);
      pwc_tb_row_t w;
      pwc_pkg::pwc_media_t e;
      logic [47:0] a;
      logic [31:0] v;
      logic [7:0] b;
      int base;
      int last;
      int blk;
      w = rows[r];
      got_q.delete();
      last = w.nsec + int'(w.err != 2'd0);
      blk = (w.op == pwc_pkg::OP_FUA) ? int'(w.mult) : 1;
      slow <= w.slow;
      err_en <= 1'b0;
      ahb(1'b1, pwc_pkg::OFS_CTL, 16'h0);
      ahb(1'b1, pwc_pkg::OFS_MULT, {8'h0, w.mult});
      ahb(1'b1, pwc_pkg::OFS_DH, {8'h0, w.dh});
      // Previous bytes first
      for (int p = 0; p < 2; p++) begin
         v = (p == 0) ? w.prv : w.cur;
         for (int k = 0; k < 4; k++) begin
            if (p == 1 || w.op == pwc_pkg::OP_FUA) begin
               ahb(1'b1, pwc_pkg::OFS_SCNT + 8'(4 * k), {8'h0, 8'(v >> 8 * k)});
            end
         end
      end
      err_at <= taken_q + 16'(w.nsec * WPS);
      err_en <= (w.err != 2'd0);
      err_nf <= (w.err == 2'd2);
      base = flush_cnt_q;
      ahb(1'b1, pwc_pkg::OFS_CMD, {8'h0, w.op});
      for (int s = 0; s < last; s++) begin
         if (s == 0) begin
            poll_drq();
         end else if (s % blk == 0) begin
            wait_irq();
            rd_chk(pwc_pkg::OFS_CMD, 32'h58);
         end
         // Failing sector: first word only
         for (int k = 0; k < (s < w.nsec ? WPS : 1); k++) begin
            ahb(1'b1, pwc_pkg::OFS_DATA, {r[3:0], s[7:0], k[3:0]});
         end
         if (s < last - 1 && (s + 1) % blk != 0) begin
            repeat (10) @(posedge hclk);
            chk_reg({31'h0, intrq}, 32'h0);
         end
      end
      wait_irq();
      if (w.err == 2'd0 && w.op == pwc_pkg::OP_FUA) begin
         chk_reg(32'(flush_cnt_q), 32'(base + 1));
      end
      rd_chk(pwc_pkg::OFS_CMD, w.err != 2'd0 ? 32'h51 : 32'h50);
      @(negedge hclk);
      chk_reg({31'h0, intrq}, 32'h0);
      rd_chk(pwc_pkg::OFS_ERR, w.err == 2'd1 ? 32'h04 :
         w.err == 2'd2 ? 32'h10 : 32'h00);
      chk_reg(32'(got_q.size()), 32'(w.nsec * WPS));
      for (int i = 0; i < got_q.size(); i++) begin
         e.data = {r[3:0], 8'(i / WPS), 4'(i % WPS)};
         e.addr = w.start + 48'(i / WPS);
         e.lba = (w.op == pwc_pkg::OP_FUA) | w.dh[pwc_pkg::DH_LBA];
         chk_media(got_q[i], e);
      end
      // Result, low then high bytes
      a = w.start + 48'(w.nsec);
      for (int h = 0; h < 2; h++) begin
         if (h == 0 || w.op == pwc_pkg::OP_FUA) begin
            ahb(1'b1, pwc_pkg::OFS_CTL, h == 1 ? 16'h0080 : 16'h0000);
            b = 8'(w.remain >> 8 * h);
            rd_chk(pwc_pkg::OFS_SCNT, {24'h0, b});
            for (int k = 0; k < 3; k++) begin
               b = 8'(a >> (24 * h + 8 * k));
               rd_chk(pwc_pkg::OFS_SNUM + 8'(4 * k), {24'h0, b});
            end
         end
      end
      if (w.op != pwc_pkg::OP_FUA) begin
         ahb(1'b0, pwc_pkg::OFS_DH, 16'h0);
         chk_reg(rd_q & 32'hf, {28'h0, a[27:24]});
      end
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rows[0] = '{8'h30, 8'h01, 8'he5, 32'h0, 32'h56341201, 8'd1, 2'd0,
         48'h5563412, 16'h0, 1'b0};
      rows[1] = '{8'h31, 8'h02, 8'ha3, 32'h0, 32'h0007ff02, 8'd2, 2'd0,
         48'h30007ff, 16'h0, 1'b1};
      rows[2] = '{8'h30, 8'h01, 8'he0, 32'h0, 32'h00001000, 8'd1, 2'd1,
         48'h10, 16'h00ff, 1'b0};
      rows[3] = '{8'hce, 8'h02, 8'h40, 32'h0a0b0c00, 32'h03020103, 8'd3,
         2'd0, 48'h0a0b0c030201, 16'h0, 1'b1};
      rows[4] = '{8'hce, 8'h02, 8'h40, 32'h00000001, 32'h0000fe02, 8'd2,
         2'd1, 48'hfe, 16'h0100, 1'b0};
      rows[5] = '{8'hce, 8'h01, 8'h40, 32'hff000000, 32'h0, 8'd1, 2'd2,
         48'hff0000000000, 16'hffff, 1'b0};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(pwc_pkg::OFS_CMD, 32'h50);
      rd_chk(pwc_pkg::OFS_ERR, 32'h0);
      rd_chk(pwc_pkg::OFS_MULT, {24'h0, pwc_pkg::RST_MULT});
      rd_chk(pwc_pkg::OFS_DH, {24'h0, pwc_pkg::RST_DH});
      for (int r = 0; r < 6; r++) begin
         run_row(r);
      end
      // Unknown opcode aborts
      ahb(1'b1, pwc_pkg::OFS_CMD, 16'h0020);
      repeat (2) @(posedge hclk);
      rd_chk(pwc_pkg::OFS_CMD, 32'h51);
      rd_chk(pwc_pkg::OFS_ERR, 32'h04);
      rd_chk(8'h3c, 32'h0);
      // Data word with no request is dropped
      got_q.delete();
      ahb(1'b1, pwc_pkg::OFS_DATA, 16'hbeef);
      repeat (10) @(posedge hclk);
      chk_reg(32'(got_q.size()), 32'h0);
      close_out();
   end
   // Watchdog
   initial begin
      #900000;
      bail();
   end
endmodule
